// *** hdl/tes_trap_seq.sv ***
// Trap entry sequencer top: pushes a trap frame, updates processor
// state and forms the vector. Assumes the pipeline holds its request
// until trap_done and stalls while busy; registers via AXI4-Lite.
// How it works
// - Trap entry increments trap level first.
// - Save bank, codes, space, state, window.
// - Save pc and next pc, masked.
// - Record trap type code in one register, not per level.
// - Advance bank index, saturating at maximum.
// - Force fixed processor state bits on entry.
// - Adjust window pointer for window traps.
// - Other traps leave window pointer alone.
// - Vector from base, level bit, type.
// - No interrupts while interrupt enable clear.
// - Frame n changes only trapping from n-1.
// - Clean-window trap on dirty next window.
// - Branch trap saves branch address, next pc.
// - Branch trap delivered privileged unless hyperprivileged or new trap level above MAX_SUP_TL.
// - Processor message queue raises interrupt 07C.
// - Disabled extended instruction raises trap 02F.
// - Invalid instruction/space pairing raises 014.
// - Noncacheable special access raises trap 016.
// - Nonfaulting-only page access raises trap 017.
// - User access to privileged page raises 015.
// - Nonfaulting load to side-effect page raises 030.
// - Device message queue raises interrupt 07D.
// - Interrupt only above level, no higher exception.
`timescale 1ns/100ps
`default_nettype none
module tes_trap_seq (
  input wire logic aclk,
  input wire logic aresetn,
  // Pipeline side.
  input wire logic [11:0] cause,
  input wire logic [3:0] irq_level,
  input wire logic hyper_mode,
  input wire logic [63:0] pc,
  input wire logic [63:0] next_pc,
  input wire logic [7:0] condition_codes,
  input wire logic [7:0] address_space_id,
  input wire logic [tes_pkg::CWP_W-1:0] savable_windows,
  output logic trap_busy,
  output logic trap_done,
  output logic trap_hyper,
  output logic [63:0] vec_pc,
  output logic [63:0] vec_next_pc,
  output logic [tes_pkg::TL_W-1:0] trap_level,
  output logic [tes_pkg::GL_W-1:0] register_bank_index,
  output logic [tes_pkg::CWP_W-1:0] current_window_pointer,
  output logic [tes_pkg::PS_W-1:0] proc_state,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tes_pkg::*;
  localparam int FW = 31;
  typedef struct packed {
    tes_state_t st;
    logic [TT_W-1:0] tt;
    logic [TL_W-1:0] tl;
    logic [GL_W-1:0] gl;
    logic [CWP_W-1:0] cwp;
    logic [PS_W-1:0] ps;
    logic [63:0] trap_base;
    logic [63:0] vpc;
    logic [63:0] spc;
    logic [63:0] snpc;
    logic hyp;
    logic done;
    logic [TL_W-1:0] sel;
    logic aw_got;
    logic w_got;
    logic [7:0] awa;
    logic [31:0] wd;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [1:0] br;
  } tes_regs_t;
  tes_regs_t s_r, s_nxt;
  logic enc_valid;
  logic [TT_W-1:0] enc_tt;
  logic fr_we;
  logic [FW-1:0] fr_wd, fr_rd;
  logic [TL_W-1:0] tl_inc;
  logic [CWP_W:0] cwp_sum;
  logic [TL_W-1:0] fr_addr;

  tes_cause_enc u_enc (
    .cause(cause),
    .irq_level(irq_level),
    .processor_interrupt_level(4'h0),
    .int_en(s_r.ps[PS_IE]),
    .valid(enc_valid),
    .tt(enc_tt)
  );

  // Saved frame: bank, window, codes, space, state word, one zero bit.
  tes_frame_mem #(.DW(FW), .AW(TL_W)) u_frame (
    .aclk(aclk),
    .we(fr_we),
    .waddr(fr_addr),
    .wdata(fr_wd),
    .raddr(s_r.sel),
    .rdata(fr_rd)
  );

  assign tl_inc = s_r.tl + TL_W'(1);
  assign fr_addr = (s_r.st == ST_WRITE) ? s_r.tl : s_r.sel;

  // Window sum kept one bit wider so the modulo wrap is explicit.
  always_comb begin
    cwp_sum = {1'b0, s_r.cwp};
    if (s_r.tt == TT_CLEAN) begin
      cwp_sum = {1'b0, s_r.cwp} + (CWP_W+1)'(1);
    end else if (s_r.tt >= TT_SPILL_LO && s_r.tt <= TT_SPILL_HI) begin
      cwp_sum = {1'b0, s_r.cwp} + {1'b0, savable_windows} + (CWP_W+1)'(2);
    end else if (s_r.tt >= TT_FILL_LO && s_r.tt <= TT_FILL_HI) begin
      cwp_sum = {1'b0, s_r.cwp} + {1'b0, NWIN_MAX};
    end
  end

  // Frame write happens in ST_WRITE only.
  always_comb begin
    fr_we = 1'b0;
    fr_wd = {s_r.gl, s_r.cwp, condition_codes, address_space_id,
             s_r.ps, 1'b0};
    if (s_r.st == ST_WRITE) begin
      fr_we = 1'b1;
      fr_wd = {s_r.gl, s_r.cwp, condition_codes, address_space_id,
               s_r.ps, 1'b0};
    end
  end

  // Next state: trap sequence plus the bus slave.
  always_comb begin
    logic wr_go;
    logic [63:0] v;
    wr_go = 1'b0;
    v = '0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (enc_valid && s_r.tl != MAX_TL) begin
          s_nxt.tl = tl_inc;
          s_nxt.tt = enc_tt;
          // Branch trap keeps the branch address, not the target.
          s_nxt.spc = s_r.ps[PS_AM] ? {32'h0000_0000, pc[31:0]} : pc;
          s_nxt.snpc = s_r.ps[PS_AM] ?
                       {32'h0000_0000, next_pc[31:0]} : next_pc;
          s_nxt.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // All visible state but trap level, saved pcs and busy flips in this one edge.
        s_nxt.gl = (s_r.gl == MAX_GL) ? MAX_GL :
                   s_r.gl + GL_W'(1);
        s_nxt.cwp = cwp_sum[CWP_W-1:0];
        s_nxt.ps[PS_FPU] = 1'b1;
        s_nxt.ps[PS_AM] = 1'b0;
        s_nxt.ps[PS_SUP] = 1'b1;
        s_nxt.ps[PS_BO] = s_r.ps[PS_TBO];
        s_nxt.ps[PS_IE] = 1'b0;
        s_nxt.ps[PS_TOB] = 1'b0;
        v = {s_r.trap_base[63:15], (s_r.tl > TL_W'(1)), s_r.tt, 5'h00};
        s_nxt.vpc = v;
        // Branch trap from hyper mode stays hyper.
        s_nxt.hyp = hyper_mode || (s_r.tl > MAX_SUP_TL);
        s_nxt.done = 1'b1;
        s_nxt.st = ST_DONE;
      end
      ST_DONE: s_nxt.st = ST_IDLE;
      default: s_nxt.st = ST_IDLE;
    endcase
    // Write channel capture in either order.
    if (s_axi_awvalid && !s_r.aw_got) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wd = s_axi_wdata;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bv) begin
      wr_go = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.br = RESP_OK;
      case (s_r.awa)
        A_CTRL: begin
          // Ignored while a trap is taken or in flight.
          if (s_r.st == ST_IDLE && s_nxt.st == ST_IDLE) begin
            s_nxt.ps = s_r.wd[PS_W-1:0];
            s_nxt.gl = s_r.wd[16 +: GL_W];
            s_nxt.tl = s_r.wd[24 +: TL_W];
          end
        end
        A_TBA_LO: s_nxt.trap_base[31:15] = s_r.wd[31:15];
        A_TBA_HI: s_nxt.trap_base[63:32] = s_r.wd;
        A_FRAME_SEL: s_nxt.sel = s_r.wd[TL_W-1:0];
        default: s_nxt.br = RESP_ERR;
      endcase
    end
    if (s_r.bv && s_axi_bready) s_nxt.bv = 1'b0;
    if (s_axi_arvalid && !s_r.rv) begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = RESP_OK;
      case (s_axi_araddr)
        A_CTRL: s_nxt.rd = {5'h00, s_r.tl, 6'h00, s_r.gl,
                            7'h00, s_r.ps};
        A_STATUS: s_nxt.rd = {22'h000000, s_r.cwp,
                              s_r.hyp, s_r.st != ST_IDLE, 5'h00};
        A_TBA_LO: s_nxt.rd = {s_r.trap_base[31:15], 15'h0000};
        A_TBA_HI: s_nxt.rd = s_r.trap_base[63:32];
        A_FRAME_SEL: s_nxt.rd = {29'h0000_0000, s_r.sel};
        A_FR_PCLO: s_nxt.rd = s_r.spc[31:0];
        A_FR_NPCLO: s_nxt.rd = s_r.snpc[31:0];
        A_FR_MISC: s_nxt.rd = {1'b0, fr_rd};
        A_VEC_LO: s_nxt.rd = s_r.vpc[31:0];
        A_VEC_HI: s_nxt.rd = s_r.vpc[63:32];
        default: begin
          s_nxt.rd = 32'h0000_0000;
          s_nxt.rr = RESP_ERR;
        end
      endcase
    end
    if (s_r.rv && s_axi_rready) s_nxt.rv = 1'b0;
    if (wr_go && s_axi_wstrb == 4'h0) s_nxt.br = RESP_OK;
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ps <= PS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trap_busy = (s_r.st != ST_IDLE);
  assign trap_done = s_r.done;
  assign trap_hyper = s_r.hyp;
  assign vec_pc = s_r.vpc;
  assign vec_next_pc = s_r.vpc + 64'h4;
  assign trap_level = s_r.tl;
  assign register_bank_index = s_r.gl;
  assign current_window_pointer = s_r.cwp;
  assign proc_state = s_r.ps;
  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready = !s_r.w_got;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.br;
  assign s_axi_arready = !s_r.rv;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = s_r.rd;
  assign s_axi_rresp = s_r.rr;

  // Checks kept beside the logic they guard.
  a_level_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == ST_IDLE && s_nxt.st == ST_WRITE) |=>
    s_r.tl == $past(s_r.tl) + TL_W'(1))
    else $error("trap level did not step by one");
  a_state_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_done |-> proc_state[PS_SUP] && !proc_state[PS_IE] &&
    !proc_state[PS_AM] && proc_state[PS_FPU])
    else $error("processor state not forced on entry");
  a_bank_sat: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_done |-> register_bank_index <= MAX_GL)
    else $error("bank index above maximum");
  a_done_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == ST_WRITE) |=> trap_done ##1 !trap_busy)
    else $error("entry did not finish in two cycles");
  a_vec_low: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_done |-> vec_pc[4:0] == 5'h00 &&
    vec_pc[13:5] == s_r.tt)
    else $error("vector low bits wrong");
  a_ie_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_r.ps[PS_IE] && cause[10:8] != 3'h0 && cause[7:0] == 8'h00)
    |-> !enc_valid)
    else $error("interrupt taken while disabled");
  a_pc_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == ST_IDLE && s_nxt.st == ST_WRITE && s_r.ps[PS_AM])
    |=> s_r.spc[63:32] == 32'h0000_0000)
    else $error("saved pc not masked");
  a_cwp_plain: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == ST_WRITE && s_r.tt < TT_SPILL_LO && s_r.tt != TT_CLEAN)
    |=> $stable(current_window_pointer))
    else $error("window pointer moved on plain trap");
endmodule : tes_trap_seq
`default_nettype wire

// *** hdl/tes_pkg.sv ***
// Package for the trap entry sequencer: register map, field layout,
// trap type codes and state encodings.
// Assumes one core clock domain and an AXI4-Lite register bus.
package tes_pkg;
  localparam int TL_W = 3;
  localparam int GL_W = 2;
  localparam int CWP_W = 3;
  localparam int TT_W = 9;
  localparam logic [TL_W-1:0] MAX_TL = 3'h6;
  localparam logic [TL_W-1:0] MAX_SUP_TL = 3'h2;
  localparam logic [GL_W-1:0] MAX_GL = 2'h3;
  localparam logic [CWP_W-1:0] NWIN_MAX = 3'h7;
  // Trap type codes.
  localparam logic [TT_W-1:0] TT_CLEAN = 9'h024;
  localparam logic [TT_W-1:0] TT_SPILL_LO = 9'h080;
  localparam logic [TT_W-1:0] TT_SPILL_HI = 9'h0BF;
  localparam logic [TT_W-1:0] TT_FILL_LO = 9'h0C0;
  localparam logic [TT_W-1:0] TT_FILL_HI = 9'h0FF;
  localparam logic [TT_W-1:0] TT_INV_ASI = 9'h014;
  localparam logic [TT_W-1:0] TT_PRIV_PG = 9'h015;
  localparam logic [TT_W-1:0] TT_NC_PG = 9'h016;
  localparam logic [TT_W-1:0] TT_NFO_PG = 9'h017;
  localparam logic [TT_W-1:0] TT_FEAT = 9'h02F;
  localparam logic [TT_W-1:0] TT_SIDE_PG = 9'h030;
  localparam logic [TT_W-1:0] TT_BRANCH = 9'h074;
  localparam logic [TT_W-1:0] TT_CPU_MSG = 9'h07C;
  localparam logic [TT_W-1:0] TT_DEV_MSG = 9'h07D;
  localparam logic [TT_W-1:0] TT_INT_BASE = 9'h040;
  // Processor state word bit positions.
  localparam int PS_BO = 0;
  localparam int PS_TBO = 1;
  localparam int PS_IE = 2;
  localparam int PS_SUP = 3;
  localparam int PS_AM = 4;
  localparam int PS_FPU = 5;
  localparam int PS_TOB = 6;
  localparam int PS_MM0 = 7;
  localparam int PS_W = 9;
  localparam logic [PS_W-1:0] PS_RESET = 9'h00C;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_TBA_LO = 8'h08;
  localparam logic [7:0] A_TBA_HI = 8'h0C;
  localparam logic [7:0] A_FRAME_SEL = 8'h10;
  localparam logic [7:0] A_FR_PCLO = 8'h14;
  localparam logic [7:0] A_FR_NPCLO = 8'h18;
  localparam logic [7:0] A_FR_MISC = 8'h1C;
  localparam logic [7:0] A_VEC_LO = 8'h20;
  localparam logic [7:0] A_VEC_HI = 8'h24;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_DONE = 2'h3
  } tes_state_t;
endpackage : tes_pkg

// *** hdl/tes_frame_mem.sv ***
// Per-level trap frame memory: one word per trap level, registered read.
// Assumes writer and reader share the core clock.
`timescale 1ns/100ps
`default_nettype none
module tes_frame_mem #(
  parameter int DW = 8,
  parameter int AW = 3
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  // Write port and registered read port; no reset needed for contents.
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : tes_frame_mem
`default_nettype wire

// *** hdl/tes_cause_enc.sv ***
// Exception cause encoder: turns pipeline cause flags into a trap type.
// Assumes flags come from the core clock domain, already qualified.
`timescale 1ns/100ps
`default_nettype none
module tes_cause_enc (
  input wire logic [11:0] cause,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] processor_interrupt_level,
  input wire logic int_en,
  output logic valid,
  output logic [tes_pkg::TT_W-1:0] tt
);
  import tes_pkg::*;
  // Lowest index wins; interrupts come last so any exception is first.
  always_comb begin
    valid = 1'b1;
    tt = '0;
    if (cause[0]) tt = TT_INV_ASI;
    else if (cause[1]) tt = TT_PRIV_PG;
    else if (cause[2]) tt = TT_NC_PG;
    else if (cause[3]) tt = TT_NFO_PG;
    else if (cause[4]) tt = TT_FEAT;
    else if (cause[5]) tt = TT_SIDE_PG;
    else if (cause[6]) tt = TT_BRANCH;
    else if (cause[7]) tt = TT_CLEAN;
    else if (cause[8] && int_en) tt = TT_CPU_MSG;
    else if (cause[9] && int_en) tt = TT_DEV_MSG;
    else if (cause[10] && int_en && irq_level > processor_interrupt_level) begin
      tt = TT_INT_BASE | {5'h00, irq_level};
    end else valid = 1'b0;
  end
endmodule : tes_cause_enc
`default_nettype wire

// *** test/tes_pipe_model.sv ***
// Pipeline model that raises trap cause flags for the sequencer.
// Assumes the core clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tes_pipe_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [11:0] flags,
  input wire logic trap_done,
  output logic [11:0] cause
);
  // The core stalls on a pending trap, so the flags stay up until the
  // answer; stop withdraws a request that the sequencer never takes.
  always_ff @(posedge aclk) begin
    if (!aresetn || trap_done || stop) begin
      cause <= 12'h000;
    end else if (start) begin
      cause <= flags;
    end
  end
endmodule // tes_pipe_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the trap entry sequencer.
// Assumes the pipeline model beside it and AXI4-Lite register access.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
  import tes_pkg::*;
  int checked = 0;
  int mismatches = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic start = 1'b0, stop = 1'b0, hyper_mode = 1'b0;
  logic [11:0] flags = 12'h000, cause;
  logic [3:0] irq_level = 4'h5;
  logic [63:0] pc = 64'hFFFF_0000_1234_5670;
  logic [63:0] next_pc = 64'hFFFF_0000_1234_5674;
  logic [7:0] ccr = 8'h5A, asi = 8'h80, awaddr = 8'h00, araddr = 8'h00;
  logic [CWP_W-1:0] savable = 3'h2, cwp;
  logic trap_busy, trap_done, trap_hyper;
  logic [63:0] vec_pc, vec_next_pc;
  logic [TL_W-1:0] tl;
  logic [GL_W-1:0] gl;
  logic [PS_W-1:0] ps;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [63:0] trap_base = {32'h0000_00A5, 32'hCAFE_8000};
  // Expected trap type for each cause flag, lowest flag first.
  logic [TT_W-1:0] tts [0:10] = '{TT_INV_ASI, TT_PRIV_PG, TT_NC_PG,
    TT_NFO_PG, TT_FEAT, TT_SIDE_PG, TT_BRANCH, TT_CLEAN, TT_CPU_MSG,
    TT_DEV_MSG, TT_INT_BASE + 9'h005};

  // Free-running core clock, 10 ns period.
  always #5 aclk = ~aclk;

  tes_pipe_model i_tes_pipe_model (.aclk(aclk), .aresetn(aresetn),
    .start(start), .stop(stop), .flags(flags), .trap_done(trap_done),
    .cause(cause));

  tes_trap_seq i_tes_trap_seq (.aclk(aclk), .aresetn(aresetn),
    .cause(cause), .irq_level(irq_level), .hyper_mode(hyper_mode),
    .pc(pc), .next_pc(next_pc), .condition_codes(ccr),
    .address_space_id(asi), .savable_windows(savable),
    .trap_busy(trap_busy), .trap_done(trap_done), .trap_hyper(trap_hyper),
    .vec_pc(vec_pc), .vec_next_pc(vec_next_pc), .trap_level(tl),
    .register_bank_index(gl), .current_window_pointer(cwp),
    .proc_state(ps), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // Privileged vector: base bits 63:15, level bit, type, five zeros.
  function automatic logic [63:0] vexp(input logic b,
                                       input logic [TT_W-1:0] t);
    return {trap_base[63:15], b, t, 5'h00};
  endfunction

  // Handshakes are judged at the falling edge, where nothing moves.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ah, wh, an, wn;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge aclk);
      an = awvalid && awready;
      wn = wvalid && wready;
      @(posedge aclk);
      if (an) awvalid <= 1'b0;
      if (wn) wvalid <= 1'b0;
      ah = ah | an;
      wh = wh | wn;
    end
    bready <= 1'b1;
    do @(negedge aclk); while (!bvalid);
    `CHK("bresp", er, bresp)
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask

  // Raise one cause and return in the cycle where trap_done stands.
  task automatic trap(input logic [11:0] f);
    int n;
    @(posedge aclk);
    flags <= f;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!trap_done && n < 20);
    `CHK("trap_done", 1'b1, trap_done)
    `CHK("trap_busy", 1'b1, trap_busy)
  endtask

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("ps_reset", PS_RESET, ps)
    `CHK("tl_reset", 3'h0, tl)
    axw(A_TBA_LO, trap_base[31:0], RESP_OK);
    axw(A_TBA_HI, trap_base[63:32], RESP_OK);
    axr(A_TBA_LO, rd, rs);
    `CHK("tba_lo", trap_base[31:0], rd)
    axr(8'h40, rd, rs);
    `CHK("unmapped_resp", RESP_ERR, rs)
    `CHK("unmapped_data", 32'h0, rd)
    axw(8'h44, 32'hFFFF_FFFF, RESP_ERR);
    // Masking, trap byte-order bit, trap-on-branch and memory model set.
    axw(A_CTRL, 32'h0000_015E, RESP_OK);
    trap(12'h001);
    `CHK("tl", 3'h1, tl)
    `CHK("gl", 2'h1, gl)
    `CHK("ps", 9'h12B, ps)
    `CHK("cwp", 3'h0, cwp)
    `CHK("vec", vexp(1'b0, TT_INV_ASI), vec_pc)
    `CHK("vec_nx", vexp(1'b0, TT_INV_ASI) + 64'h4, vec_next_pc)
    axw(A_FRAME_SEL, 32'h1, RESP_OK);
    axr(A_FR_PCLO, rd, rs);
    `CHK("saved_pc", pc[31:0], rd)
    axr(A_FR_NPCLO, rd, rs);
    `CHK("saved_npc", next_pc[31:0], rd)
    axr(A_FR_MISC, rd, rs);
    `CHK("frame", {6'h00, ccr, asi, 9'h15E, 1'b0}, rd)
    trap(12'h080);
    `CHK("cwp", 3'h1, cwp)
    `CHK("vec", vexp(1'b1, TT_CLEAN), vec_pc)
    `CHK("ps", 9'h12B, ps)
    trap(12'h040);
    `CHK("gl", 2'h3, gl)
    `CHK("hyper", 1'b1, trap_hyper)
    trap(12'h001);
    `CHK("gl", 2'h3, gl)
    `CHK("tl", 3'h4, tl)
    // An interrupt while interrupts are off must never be taken.
    @(posedge aclk);
    flags <= 12'h100;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (8) @(posedge aclk);
    stop <= 1'b1;
    @(posedge aclk);
    stop <= 1'b0;
    @(negedge aclk);
    `CHK("tl_irq_off", 3'h4, tl)
    // Every cause flag from a clean level zero with interrupts on.
    for (int i = 0; i < 11; i++) begin
      axw(A_CTRL, 32'h0000_000C, RESP_OK);
      trap(12'h001 << i);
      `CHK("tt", tts[i], vec_pc[13:5])
      `CHK("hyper", 1'b0, trap_hyper)
      `CHK("tl", 3'h1, tl)
    end
    axw(A_CTRL, 32'h0000_000C, RESP_OK);
    @(posedge aclk);
    hyper_mode <= 1'b1;
    trap(12'h040);
    `CHK("hyper_branch", 1'b1, trap_hyper)
    conclude;
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude;
  end
endmodule // tb
`default_nettype wire
